// [verilog/i2c_slave_hold.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Collision detect on: SDA low at SCL rise while releasing high sets flag.
// - Address hold: matching address byte clears clock release, SCL held low.
// - Ack window flag only works when address or data hold is enabled.
// - Mask bits 7..1 set to one include that address bit in matching.
// - Ten-bit modes: mask bit 0 decides whether address bit 0 counts.
// - Seven-bit mode ignores mask bit 0.
// - Master mode SCL period is four times divider plus one clocks.
// - Ten-bit high byte prefix 11110 is checked in hardware.
// - Ten-bit high byte uses stored bits 2 and 1, ignores bit 0.
// - Ten-bit low byte compares all eight stored bits.
// - Seven-bit mode uses stored bits 7..1, bit 0 is don't-care.
module i2c_slave_hold
	import i2c_hold_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire bus_in_s bus_in,
	input wire logic sda_drive_high,
	output bus_out_s bus_out,
	output logic irq
);
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_ADDR = 4'b0010,
		ST_DATA = 4'b0100,
		ST_ACK = 4'b1000
	} phase_e;

	phase_e state_q;
	logic [7:0] control_three_q;
	logic [7:0] mask_q;
	logic [7:0] slave_address_q;
	logic [7:0] control_one_q;
	logic [2:0] irq_status_q;
	logic [2:0] irq_mask_q;
	logic scl_q;
	logic sda_q;
	logic [7:0] shift_q;
	logic [3:0] bit_cnt_q;
	logic ten_high_q;
	logic addressed_q;
	logic ack_window_q;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic wr_access;
	logic rd_access;
	logic [3:0] mode;
	logic ten_bit;
	logic master_mode;
	logic hold_en;
	logic byte_match;
	logic byte_done;
	logic hold_event;
	logic collision_event;
	logic release_write;
	logic master_scl_low;
	logic [7:0] rx_byte;
	logic [2:0] irq_events;

	assign mode = control_one_q[MODE_LSB +: 4];
	assign ten_bit = (mode == MODE_SLAVE_10BIT) || (mode == MODE_SLAVE_10BIT_IRQ);
	assign master_mode = (mode == MODE_MASTER);
	assign hold_en = control_three_q[ADDRESS_HOLD_BIT]
		|| control_three_q[DATA_HOLD_BIT];
	assign scl_rise = bus_in.scl && !scl_q;
	assign scl_fall = !bus_in.scl && scl_q;
	assign start_seen = scl_q && bus_in.scl && sda_q && !bus_in.sda;
	assign stop_seen = scl_q && bus_in.scl && !sda_q && bus_in.sda;
	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && !penable && !pwrite;
	assign rx_byte = shift_q;
	assign byte_done = scl_fall && (bit_cnt_q == BITS_PER_BYTE);
	assign collision_event = control_three_q[COLLISION_DETECT_BIT]
		&& sda_drive_high && scl_rise && !bus_in.sda;
	assign hold_event = byte_done && (((state_q == ST_ADDR) && byte_match
		&& control_three_q[ADDRESS_HOLD_BIT])
		|| ((state_q == ST_DATA) && control_three_q[DATA_HOLD_BIT]));
	assign release_write = wr_access && (paddr == ADDR_CONTROL_ONE);
	assign irq_events = {hold_event, byte_done && byte_match
		&& (state_q == ST_ADDR), collision_event};

	addr_matcher u_match
	(
		.rx_byte(rx_byte),
		.stored(slave_address_q),
		.mask(mask_q),
		.ten_bit(ten_bit),
		.high_byte(!addressed_q && !ten_high_q),
		.match(byte_match)
	);

	scl_divider u_div
	(
		.pclk(pclk),
		.presetn(presetn),
		.run(master_mode),
		.divider(slave_address_q),
		.scl_low(master_scl_low)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= bus_in.scl;
			sda_q <= bus_in.sda;
		end
	end

	// Byte framing: eight rising edges shift in, the eighth fall ends the byte.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			ten_high_q <= 1'b0;
			addressed_q <= 1'b0;
		end
		else if (start_seen && !master_mode)
		begin
			state_q <= ST_ADDR;
			bit_cnt_q <= 4'h0;
			ten_high_q <= 1'b0;
			addressed_q <= 1'b0;
		end
		else if (stop_seen)
		begin
			state_q <= ST_IDLE;
			addressed_q <= 1'b0;
		end
		else
		begin
			if (scl_rise && bit_cnt_q < BITS_PER_BYTE)
			begin
				shift_q <= {shift_q[6:0], bus_in.sda};
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
			unique case (state_q)
				ST_IDLE:
				begin
				end
				ST_ADDR:
				begin
					if (byte_done)
					begin
						if (!byte_match)
						begin
							state_q <= ST_IDLE;
						end
						else if (ten_bit && !ten_high_q)
						begin
							ten_high_q <= 1'b1;
							state_q <= ST_ACK;
						end
						else
						begin
							addressed_q <= 1'b1;
							state_q <= ST_ACK;
						end
					end
				end
				ST_DATA:
				begin
					if (byte_done)
					begin
						state_q <= ST_ACK;
					end
				end
				ST_ACK:
				begin
					if (scl_rise)
					begin
						bit_cnt_q <= 4'h0;
						state_q <= addressed_q ? ST_DATA : ST_ADDR;
					end
				end
			endcase
		end
	end

	// Ack window: set on eighth fall, cleared on ninth rise.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack_window_q <= 1'b0;
		end
		else if (!hold_en)
		begin
			ack_window_q <= 1'b0;
		end
		else if (byte_done && ((state_q == ST_ADDR && byte_match)
			|| state_q == ST_DATA))
		begin
			ack_window_q <= 1'b1;
		end
		else if (state_q == ST_ACK && scl_rise)
		begin
			ack_window_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			control_three_q <= CONTROL_THREE_RESET;
			mask_q <= MASK_RESET;
			slave_address_q <= SLAVE_ADDRESS_RESET;
			irq_mask_q <= 3'h0;
		end
		else if (wr_access)
		begin
			unique case (paddr)
				ADDR_CONTROL_THREE: control_three_q <= pwdata[7:0];
				ADDR_MASK: mask_q <= pwdata[7:0];
				ADDR_SLAVE_ADDRESS: slave_address_q <= pwdata[7:0];
				ADDR_IRQ_MASK: irq_mask_q <= pwdata[2:0];
				default:
				begin
				end
			endcase
		end
	end

	// Hardware clearing the release bit wins over a same-cycle write.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			control_one_q <= CONTROL_ONE_RESET;
		end
		else if (hold_event)
		begin
			control_one_q[CLOCK_RELEASE_BIT] <= 1'b0;
			if (release_write)
			begin
				control_one_q[MODE_LSB +: 4] <= pwdata[MODE_LSB +: 4];
			end
		end
		else if (release_write)
		begin
			control_one_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_status_q <= 3'h0;
		end
		else
		begin
			irq_status_q <= (irq_status_q & ~((wr_access
				&& paddr == ADDR_IRQ_STATUS) ? pwdata[2:0] : 3'h0))
				| irq_events;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq <= 1'b0;
			bus_out <= '0;
		end
		else
		begin
			irq <= |(irq_status_q & irq_mask_q);
			bus_out.scl_oe <= master_mode ? master_scl_low
				: !control_one_q[CLOCK_RELEASE_BIT];
			bus_out.sda_oe <= 1'b0;
		end
	end

	// Registers answer in the access cycle with no wait state.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !(paddr inside {ADDR_CONTROL_THREE,
				ADDR_MASK, ADDR_SLAVE_ADDRESS, ADDR_CONTROL_ONE,
				ADDR_IRQ_STATUS, ADDR_IRQ_MASK});
			if (rd_access)
			begin
				unique case (paddr)
					ADDR_CONTROL_THREE: prdata <= {24'h0, ack_window_q,
						control_three_q[6:0]};
					ADDR_MASK: prdata <= {24'h0, mask_q};
					ADDR_SLAVE_ADDRESS: prdata <= {24'h0, slave_address_q};
					ADDR_CONTROL_ONE: prdata <= {24'h0, control_one_q};
					ADDR_IRQ_STATUS: prdata <= {29'h0, irq_status_q};
					ADDR_IRQ_MASK: prdata <= {29'h0, irq_mask_q};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [verilog/i2c_hold_pkg.sv]
package i2c_hold_pkg;

	// APB byte addresses of the registers.
	localparam logic [7:0] ADDR_CONTROL_THREE = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_SLAVE_ADDRESS = 8'h08;
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

	// Field positions in port_control_three.
	localparam int ACK_WINDOW_BIT = 7;
	localparam int COLLISION_DETECT_BIT = 2;
	localparam int ADDRESS_HOLD_BIT = 1;
	localparam int DATA_HOLD_BIT = 0;

	// Field positions in port_control_one.
	localparam int CLOCK_RELEASE_BIT = 4;
	localparam int MODE_LSB = 0;

	// Interrupt status bit positions.
	localparam int IRQ_COLLISION_BIT = 0;
	localparam int IRQ_ADDRESS_MATCH_BIT = 1;
	localparam int IRQ_HOLD_BIT = 2;

	// Reset values.
	localparam logic [7:0] CONTROL_THREE_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [7:0] SLAVE_ADDRESS_RESET = 8'h00;
	localparam logic [7:0] CONTROL_ONE_RESET = 8'h10;

	// Mode select codes.
	localparam logic [3:0] MODE_SLAVE_7BIT = 4'h6;
	localparam logic [3:0] MODE_SLAVE_10BIT = 4'h7;
	localparam logic [3:0] MODE_SLAVE_10BIT_IRQ = 4'hf;
	localparam logic [3:0] MODE_SLAVE_7BIT_IRQ = 4'he;
	localparam logic [3:0] MODE_MASTER = 4'h8;

	// Fixed high-byte prefix of a ten-bit address.
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;

	// Bits received on the bus in one byte.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Master-mode clock is four oscillator periods per divider step.
	localparam int DIVIDER_STEPS = 4;

	typedef struct packed
	{
		logic scl;
		logic sda;
	} bus_in_s;

	typedef struct packed
	{
		logic scl_oe;
		logic sda_oe;
	} bus_out_s;

endpackage

// [verilog/addr_matcher.sv]
`timescale 1ns/1ps
`default_nettype none
module addr_matcher
	import i2c_hold_pkg::*;
(
	input wire logic [7:0] rx_byte,
	input wire logic [7:0] stored,
	input wire logic [7:0] mask,
	input wire logic ten_bit,
	input wire logic high_byte,
	output logic match
);
	logic [7:0] eff_mask;
	logic [7:0] expect_byte;

	always_comb
	begin
		eff_mask = mask;
		expect_byte = stored;
		if (!ten_bit)
		begin
			eff_mask[0] = 1'b0;
		end
		else if (high_byte)
		begin
			expect_byte = {TEN_BIT_PREFIX, stored[2:1], 1'b0};
			eff_mask = {5'h1f, mask[2:1], 1'b0};
		end
		// Low byte keeps all eight stored bits and mask bits.
		match = ((rx_byte ^ expect_byte) & eff_mask) == 8'h00;
	end
endmodule
`default_nettype wire

// [verilog/scl_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module scl_divider
	import i2c_hold_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [7:0] divider,
	output logic scl_low
);
	// Each half period lasts two clocks per step over N+1 steps, so a full period is 4*(N+1).
	logic [9:0] count_q;
	logic [9:0] half_len;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_q <= 10'h000;
			scl_low <= 1'b0;
		end
		else if (!run)
		begin
			count_q <= 10'h000;
			scl_low <= 1'b0;
		end
		else if (count_q >= half_len)
		begin
			count_q <= 10'h000;
			scl_low <= ~scl_low;
		end
		else
		begin
			count_q <= count_q + 10'h001;
		end
	end

	always_comb
	begin
		half_len = 10'((({2'b00, divider} + 10'h001) * 10'(DIVIDER_STEPS / 2))
			- 10'h001);
	end
endmodule
`default_nettype wire

// [sim/i2c_slave_hold_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_hold_checker
	import i2c_hold_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire bus_out_s bus_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr, oe_q, mst_q, seen_q;
	logic [7:0] div_q;
	logic [9:0] run_q;
	assign wr = psel && penable && pready && pwrite;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			{mst_q, div_q} <= 9'h0;
		else if (wr && paddr == ADDR_CONTROL_ONE)
			mst_q <= pwdata[3:0] == MODE_MASTER;
		else if (wr && paddr == ADDR_SLAVE_ADDRESS)
			div_q <= pwdata[7:0];
	end
	// The first toggle after entering master mode ends a partial phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			{oe_q, seen_q, run_q} <= 12'h0;
		else
		begin
			oe_q <= bus_out.scl_oe;
			run_q <= (bus_out.scl_oe != oe_q) ? 10'h1 : run_q + 10'h1;
			seen_q <= mst_q && (seen_q || bus_out.scl_oe != oe_q);
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_release;
		wr && paddr == ADDR_CONTROL_ONE && pwdata[CLOCK_RELEASE_BIT];
	endsequence
	a_ready_follows: assert property (s_setup |=> pready)
		else $error("pready missing in access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready stood two cycles");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_unmapped_error: assert property (s_setup ##0 paddr > ADDR_IRQ_MASK
		|=> pslverr) else $error("unmapped access not refused");
	a_mapped_ok: assert property (s_setup ##0 paddr <= ADDR_IRQ_MASK
		##0 paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped refused");
	a_sda_released: assert property (!bus_out.sda_oe)
		else $error("sda driven");
	a_release_clock: assert property (s_release ##0 pwdata[3:0] !=
		MODE_MASTER |=> ##[0:2] !bus_out.scl_oe) else $error("scl held");
	a_master_period: assert property (mst_q && seen_q &&
		bus_out.scl_oe != oe_q |-> run_q == ({2'b0, div_q} + 10'h1) << 1)
		else $error("master scl phase length wrong");
endmodule
bind i2c_slave_hold i2c_slave_hold_checker u_i2c_slave_hold_checker (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .bus_out(bus_out));
`default_nettype wire

// [sim/i2c_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model
(
	input wire logic pclk,
	output logic scl_m,
	output logic sda_m
);
	initial
	begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	task automatic idle();
	begin
		scl_m <= 1'b1;
		sda_m <= 1'b1;
	end
	endtask
	// SCL is left low after the byte, so a slave stretch is never overrun.
	task automatic send_byte(input logic [7:0] b);
	begin
		sda_m <= 1'b0;
		repeat (4) @(posedge pclk);
		scl_m <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			sda_m <= b[i];
			repeat (4) @(posedge pclk);
			scl_m <= 1'b1;
			repeat (4) @(posedge pclk);
			scl_m <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		sda_m <= 1'b1;
	end
	endtask
	// Ninth clock with SDA already released, so the next byte can follow.
	task automatic ack_clock();
	begin
		repeat (4) @(posedge pclk);
		scl_m <= 1'b1;
		repeat (4) @(posedge pclk);
		scl_m <= 1'b0;
		repeat (4) @(posedge pclk);
	end
	endtask
endmodule
`default_nettype wire

// [sim/tb_i2c_slave_hold.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_slave_hold
	import i2c_hold_pkg::*;
;
	typedef struct packed {logic [3:0] mode;
		logic [7:0] ctl3, addr, mask, rx; logic m;} case_s;
	case_s tv [7] = '{
		'{MODE_SLAVE_7BIT, 8'h02, 8'ha4, 8'hff, 8'ha5, 1'b1},
		'{MODE_SLAVE_7BIT_IRQ, 8'h02, 8'ha4, 8'hfd, 8'ha6, 1'b1},
		'{MODE_SLAVE_7BIT, 8'h02, 8'ha4, 8'hff, 8'ha6, 1'b0},
		'{MODE_SLAVE_7BIT, 8'h00, 8'ha4, 8'hff, 8'ha4, 1'b1},
		'{MODE_SLAVE_10BIT, 8'h02, 8'h06, 8'hff, 8'hf7, 1'b1},
		'{MODE_SLAVE_10BIT_IRQ, 8'h02, 8'h06, 8'hff, 8'h77, 1'b0},
		'{MODE_SLAVE_10BIT, 8'h02, 8'h04, 8'hff, 8'hf6, 1'b0}};
	logic [7:0] dv [2] = '{8'h00, 8'h05};
	logic pclk, presetn, psel, penable, pwrite, sda_drive_high;
	logic pready, pslverr, irq, er, scl_m, sda_m, h;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	bus_in_s bus_in;
	bus_out_s bus_out;
	int fails = 0, checks = 0, cyc = 0, k;
	// Wired-AND: either party pulling low wins on both lines.
	assign bus_in = {scl_m & ~bus_out.scl_oe, sda_m & ~bus_out.sda_oe};
	i2c_slave_hold u_i2c_slave_hold (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_in(bus_in),
		.sda_drive_high(sda_drive_high), .bus_out(bus_out), .irq(irq));
	i2c_master_model u_i2c_master_model (.pclk(pclk), .scl_m(scl_m),
		.sda_m(sda_m));
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic wrap_up();
	begin
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			wrap_up();
		end
	end
	task automatic check(input string nm, input logic [31:0] got,
		input logic [31:0] e);
	begin
		checks++;
		if (got !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, got);
		end
	end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
	begin
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	end
	endtask
	task automatic do_reset();
	begin
		@(posedge pclk);
		presetn <= 1'b0;
		sda_drive_high <= 1'b0;
		u_i2c_master_model.idle();
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	end
	endtask
	task automatic wait_oe(input logic v);
	begin
		while (bus_out.scl_oe !== v && k < 2000)
		begin
			@(posedge pclk);
			k++;
		end
	end
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, sda_drive_high} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		do_reset();
		apb(1'b0, ADDR_CONTROL_ONE, 32'h0);
		check("ctl1", rd, 32'h10);
		apb(1'b0, ADDR_SLAVE_ADDRESS, 32'h0);
		check("addr", rd, 32'h0);
		apb(1'b1, 8'h40, 32'h5a);
		check("slverr", 32'(er), 32'h1);
		foreach (tv[i])
		begin
			do_reset();
			h = tv[i].m & tv[i].ctl3[ADDRESS_HOLD_BIT];
			apb(1'b1, ADDR_SLAVE_ADDRESS, 32'(tv[i].addr));
			apb(1'b1, ADDR_MASK, 32'(tv[i].mask));
			apb(1'b1, ADDR_CONTROL_THREE, 32'(tv[i].ctl3));
			apb(1'b1, ADDR_CONTROL_ONE, {27'h0, 1'b1, tv[i].mode});
			apb(1'b1, ADDR_IRQ_MASK, 32'h2);
			u_i2c_master_model.send_byte(tv[i].rx);
			repeat (4) @(posedge pclk);
			check("stretch", 32'(bus_out.scl_oe), 32'(h));
			check("irq", 32'(irq), 32'(tv[i].m));
			apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
			check("status", rd, {29'h0, h, tv[i].m, 1'b0});
			apb(1'b0, ADDR_CONTROL_ONE, 32'h0);
			check("ctl1", rd, {27'h0, !h, tv[i].mode});
			apb(1'b0, ADDR_CONTROL_THREE, 32'h0);
			check("ctl3", rd, {24'h0, h, tv[i].ctl3[6:0]});
			apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
			apb(1'b1, ADDR_CONTROL_ONE, {27'h0, 1'b1, tv[i].mode});
			repeat (3) @(posedge pclk);
			check("irq", 32'(irq), 32'h0);
			check("unstretch", 32'(bus_out.scl_oe), 32'h0);
		end
		for (int en = 1; en >= 0; en--)
		begin
			do_reset();
			apb(1'b1, ADDR_SLAVE_ADDRESS, 32'hfe);
			apb(1'b1, ADDR_CONTROL_THREE, 32'(en << COLLISION_DETECT_BIT));
			apb(1'b1, ADDR_CONTROL_ONE, 32'h16);
			sda_drive_high <= 1'b1;
			u_i2c_master_model.send_byte(8'h00);
			apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
			check("collision", rd, 32'(en));
			check("masked", 32'(irq), 32'h0);
			apb(1'b1, ADDR_IRQ_MASK, 32'h1);
			repeat (2) @(posedge pclk);
			check("irq", 32'(irq), 32'(en));
		end
		// Ten-bit address then a data byte; mask bit 0 decides the low byte.
		for (int mb = 0; mb < 2; mb++)
		begin
			do_reset();
			apb(1'b1, ADDR_SLAVE_ADDRESS, 32'h06);
			apb(1'b1, ADDR_MASK, 32'hfe | 32'(mb));
			apb(1'b1, ADDR_CONTROL_THREE, 32'(1 << DATA_HOLD_BIT));
			apb(1'b1, ADDR_CONTROL_ONE, {27'h0, 1'b1, MODE_SLAVE_10BIT});
			u_i2c_master_model.send_byte(8'hf6);
			u_i2c_master_model.ack_clock();
			u_i2c_master_model.send_byte(8'h07);
			u_i2c_master_model.ack_clock();
			u_i2c_master_model.send_byte(8'h3c);
			repeat (4) @(posedge pclk);
			check("data hold", 32'(bus_out.scl_oe), 32'(1 - mb));
			apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
			check("status", rd, 32'h2 | 32'((1 - mb) << IRQ_HOLD_BIT));
			apb(1'b0, ADDR_CONTROL_THREE, 32'h0);
			check("ctl3", rd, 32'h1 | 32'((1 - mb) << ACK_WINDOW_BIT));
			apb(1'b1, ADDR_CONTROL_ONE, {27'h0, 1'b1, MODE_SLAVE_10BIT});
			repeat (3) @(posedge pclk);
			check("unstretch", 32'(bus_out.scl_oe), 32'h0);
		end
		foreach (dv[i])
		begin
			do_reset();
			apb(1'b1, ADDR_SLAVE_ADDRESS, 32'(dv[i]));
			apb(1'b1, ADDR_CONTROL_ONE, 32'h18);
			k = 0;
			wait_oe(1'b0);
			wait_oe(1'b1);
			k = 0;
			wait_oe(1'b0);
			wait_oe(1'b1);
			check("period", 32'(k), 32'(DIVIDER_STEPS * (dv[i] + 1)));
		end
		wrap_up();
	end
endmodule
`default_nettype wire
